// [src/akp_consts.svh]
// Offsets, reset values and field positions of the analog-capable port
`ifndef AKP_CONSTS_SVH
`define AKP_CONSTS_SVH
`define AKP_ADDR_DATA 4'h0
`define AKP_ADDR_DIR 4'h1
`define AKP_ADDR_INEN 4'h2
`define AKP_ADDR_STOP 4'h3
`define AKP_RST_DATA 8'h00
`define AKP_RST_DIR 8'h00
`define AKP_RST_INEN 8'hFF
`define AKP_RST_STOP 4'h0
`define AKP_WAKE_HI 7
`define AKP_WAKE_LO 4
`define AKP_ZERO8 8'h00
`endif

// [src/akp_pin_sync.sv]
// Two-flop synchroniser for the eight port pins
`timescale 1ns/1ps
module akp_pin_sync
    import akp_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [7:0] pin_i,
    output logic [7:0] sync_o
);
`include "akp_consts.svh"
    // First stage, read only by the second stage
    logic [7:0] meta_reg;
    // Second stage, safe for logic
    logic [7:0] sync_reg;

    // Two stages per pin against metastability
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            meta_reg <= `AKP_ZERO8;
            sync_reg <= `AKP_ZERO8;
        end
        else
        begin
            meta_reg <= pin_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;
endmodule

// [src/akp_pkg.sv]
// Types shared by the analog-capable port design
package akp_pkg;
    // Register bus request bundle
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
        logic rmw;
    } akp_bus_s;
    // Per-pin function as seen by software
    typedef enum logic [1:0] {
        AKP_MODE_ANALOG,
        AKP_MODE_INPUT,
        AKP_MODE_OUTPUT
    } akp_mode_e;
endpackage

// [src/akp_port.sv]
// Eight-bit port with analog and key-wakeup pin functions
//
// Notes on behaviour
// - Each pin configured independently by own bits
// - Reset: direction zero, input enable ones
// - Reset clears all output latch bits
// - Direction one drives latch onto pin
// - Wakeup enables sit in bits 7..4
// - Output bits read back latch contents
// - Digital input bits read synchronised pin
// - Bit-modify writes pin levels into input-pin latches
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module akp_port
    import akp_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic rmw_i,
    output logic [7:0] rdata_o,
    input wire logic [7:0] pin_i,
    output logic [7:0] pin_o,
    output logic [7:0] pin_oe_n_o,
    output logic [7:0] analog_input_select_o,
    output logic [7:0] key_wakeup_input_o
);
`include "akp_consts.svh"
    // Bundled request
    akp_bus_s bus;
    // Registers
    logic [7:0] port_data_latch_reg;
    logic [7:0] port_direction_control_reg;
    logic [7:0] port_input_enable_reg;
    logic [3:0] key_wakeup_enable_bit_reg;
    logic [7:0] rdata_reg;
    // Synchronised pin levels
    logic [7:0] pin_sync;
    // Read view of the data register
    logic [7:0] data_view;
    logic [7:0] rd_mux;
    logic [7:0] latch_next;
    // Decodes
    wire wr_data = bus.wr && (bus.addr == `AKP_ADDR_DATA);
    wire wr_dir = bus.wr && (bus.addr == `AKP_ADDR_DIR);
    wire wr_inen = bus.wr && (bus.addr == `AKP_ADDR_INEN);
    wire wr_stop = bus.wr && (bus.addr == `AKP_ADDR_STOP);

    assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i,
                   rmw: rmw_i};

    // Mode of one pin from its two control bits
    function automatic akp_mode_e pin_mode(input logic dir,
                                           input logic inen);
        if (dir)
            pin_mode = AKP_MODE_OUTPUT;
        else if (inen)
            pin_mode = AKP_MODE_INPUT;
        else
            pin_mode = AKP_MODE_ANALOG;
    endfunction

    akp_pin_sync u_sync (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .pin_i(pin_i),
        .sync_o(pin_sync)
    );

    // Per-pin read view and pin drivers
    genvar g;
    generate
        for (g = 0; g < 8; g++)
        begin : g_pin
            wire akp_mode_e m = pin_mode(port_direction_control_reg[g],
                                         port_input_enable_reg[g]);
            assign data_view[g] = (m == AKP_MODE_OUTPUT) ?
                port_data_latch_reg[g] :
                (m == AKP_MODE_INPUT) ? pin_sync[g] : 1'b0;
            assign pin_o[g] = port_data_latch_reg[g];
            assign pin_oe_n_o[g] = ~port_direction_control_reg[g];
            assign analog_input_select_o[g] = (m == AKP_MODE_ANALOG);
        end
    endgenerate

    // bit-modify writes read view back into non-output bits, written data into output bits
    // Input pins lose their latch value here; a known quirk kept on purpose
    assign latch_next = bus.rmw ?
        ((bus.wdata & port_direction_control_reg) |
         (data_view & ~port_direction_control_reg)) : bus.wdata;

    assign key_wakeup_input_o = {key_wakeup_enable_bit_reg &
        ~port_direction_control_reg[`AKP_WAKE_HI:`AKP_WAKE_LO] &
        pin_sync[`AKP_WAKE_HI:`AKP_WAKE_LO], 4'h0};

    // Read selection; unmapped reads zero
    assign rd_mux =
        (bus.addr == `AKP_ADDR_DATA) ? data_view :
        (bus.addr == `AKP_ADDR_DIR) ? port_direction_control_reg :
        (bus.addr == `AKP_ADDR_INEN) ? port_input_enable_reg :
        (bus.addr == `AKP_ADDR_STOP) ?
            {key_wakeup_enable_bit_reg, 4'h0} : `AKP_ZERO8;

    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
        begin
            port_data_latch_reg <= `AKP_RST_DATA;
            port_direction_control_reg <= `AKP_RST_DIR;
            port_input_enable_reg <= `AKP_RST_INEN;
            key_wakeup_enable_bit_reg <= `AKP_RST_STOP;
        end
        else
        begin
            if (wr_data)
                port_data_latch_reg <= latch_next;
            if (wr_dir)
                port_direction_control_reg <= bus.wdata;
            if (wr_inen)
                port_input_enable_reg <= bus.wdata;
            if (wr_stop)
                key_wakeup_enable_bit_reg <=
                    bus.wdata[`AKP_WAKE_HI:`AKP_WAKE_LO];
        end
    end

    // Read data one cycle after strobe, zero otherwise
    always_ff @(posedge ref_clk_i)
    begin
        if (rst_i)
            rdata_reg <= `AKP_ZERO8;
        else
            rdata_reg <= bus.rd ? rd_mux : `AKP_ZERO8;
    end
    assign rdata_o = rdata_reg;

    // Assertions
    // reset values; reset seen now, values one edge later
    AST_RESET_CFG: assert property (
        @(posedge ref_clk_i) rst_i |=>
        port_direction_control_reg == `AKP_RST_DIR &&
        port_input_enable_reg == `AKP_RST_INEN)
        else $error("config reset values wrong");
    AST_RESET_LATCH: assert property (
        @(posedge ref_clk_i) rst_i |=>
        port_data_latch_reg == `AKP_RST_DATA)
        else $error("latch not cleared on reset");
    AST_DRIVE: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        (pin_oe_n_o == ~port_direction_control_reg) &&
        (pin_o == port_data_latch_reg))
        else $error("pin drive mismatch");
    AST_READ_OUT: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        rd_i && addr_i == `AKP_ADDR_DATA && !wr_i |=>
        ((rdata_o ^ $past(port_data_latch_reg)) &
        $past(port_direction_control_reg)) == `AKP_ZERO8)
        else $error("output bit read wrong");
    AST_READ_IN: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        rd_i && addr_i == `AKP_ADDR_DATA |=>
        ((rdata_o ^ $past(pin_sync)) & ~$past(port_direction_control_reg) &
        $past(port_input_enable_reg)) == `AKP_ZERO8)
        else $error("input bit read wrong");
    AST_READ_ANA: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        rd_i && addr_i == `AKP_ADDR_DATA |=>
        (rdata_o & ~$past(port_direction_control_reg) &
        ~$past(port_input_enable_reg)) == `AKP_ZERO8)
        else $error("analog bit not zero");
    // bit-modify copies pins into input latches
    AST_RMW: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        wr_i && rmw_i && addr_i == `AKP_ADDR_DATA |=>
        ((port_data_latch_reg ^ $past(pin_sync)) &
        ~$past(port_direction_control_reg) &
        $past(port_input_enable_reg)) == `AKP_ZERO8)
        else $error("bit-modify lost pin level");
    // bit-modify still stores written output bits
    AST_RMW_OUT: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        wr_i && rmw_i && addr_i == `AKP_ADDR_DATA |=>
        ((port_data_latch_reg ^ $past(wdata_i)) &
        $past(port_direction_control_reg)) == `AKP_ZERO8)
        else $error("bit-modify lost output bit");
    // plain write loads the whole latch
    AST_LATCH_WR: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        wr_i && !rmw_i && addr_i == `AKP_ADDR_DATA |=>
        port_data_latch_reg == $past(wdata_i))
        else $error("latch write wrong");
    AST_WAKE: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        wr_i && addr_i == `AKP_ADDR_STOP |=> key_wakeup_enable_bit_reg ==
        $past(wdata_i[`AKP_WAKE_HI:`AKP_WAKE_LO]))
        else $error("wakeup field not stored");
    // wakeup only on enabled upper pins with direction bit clear
    AST_WAKE_OUT: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        (key_wakeup_input_o & ~({key_wakeup_enable_bit_reg, 4'h0} &
        ~port_direction_control_reg)) == `AKP_ZERO8)
        else $error("wakeup on disabled pin");
    // analog select only with both control bits clear
    AST_ANA_SEL: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        analog_input_select_o ==
        (~port_direction_control_reg & ~port_input_enable_reg))
        else $error("analog select wrong");
    // direction write loads the whole register
    AST_INDEP: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        wr_i && addr_i == `AKP_ADDR_DIR |=>
        port_direction_control_reg == $past(wdata_i))
        else $error("direction write wrong");
    COV_OUT: cover property (@(posedge ref_clk_i)
        port_direction_control_reg != `AKP_ZERO8);
    COV_ANA: cover property (@(posedge ref_clk_i)
        analog_input_select_o != `AKP_ZERO8);
    COV_RMW: cover property (@(posedge ref_clk_i) wr_i && rmw_i);
    COV_WAKE: cover property (@(posedge ref_clk_i)
        key_wakeup_input_o != `AKP_ZERO8);
endmodule

// [tb/akp_board.sv]
// Board-side pin model resolving the eight port wires
`timescale 1ns/1ps
module akp_board
(
    input wire logic [7:0] ext_i,
    input wire logic [7:0] pin_o,
    input wire logic [7:0] pin_oe_n_o,
    output logic [7:0] wire_o
);
    // Driven bits follow the latch, released bits follow the board
    assign wire_o = (pin_o & ~pin_oe_n_o) | (ext_i & pin_oe_n_o);
endmodule

// [tb/testbench.sv]
// Self-checking bench for the analog-capable port
`timescale 1ns/1ps
`include "akp_consts.svh"
module testbench;
    import akp_pkg::*;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic rmw_i = 1'b0;
    logic [7:0] ext = 8'h00;
    logic [7:0] rdata_o, pin_o, pin_oe_n_o, ana_o, wake_o, pin_w, rd_v;
    int err_count = 0;
    int compares = 0;
    int cyc = 0;
    // One row: settings, board level and expected data read
    typedef struct packed {
        logic [7:0] dir, inen, lat, ext, exp;
    } akp_row_s;
    akp_row_s rows [4] = '{
        '{8'hFF, 8'hFF, 8'h5A, 8'h00, 8'h5A},
        '{8'h00, 8'hFF, 8'h5A, 8'hC3, 8'hC3},
        '{8'h00, 8'h00, 8'h5A, 8'hFF, 8'h00},
        '{8'hF0, 8'h0C, 8'h96, 8'h3C, 8'h9C}};
    always #25 ref_clk_i = ~ref_clk_i;
    akp_port uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rmw_i(rmw_i),
        .rdata_o(rdata_o), .pin_i(pin_w), .pin_o(pin_o),
        .pin_oe_n_o(pin_oe_n_o), .analog_input_select_o(ana_o),
        .key_wakeup_input_o(wake_o));
    akp_board board (.ext_i(ext), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o),
        .wire_o(pin_w));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Single-cycle write, optionally as bit manipulation
    task automatic wr(input logic [3:0] a, input logic [7:0] d,
        input logic m);
        @(posedge ref_clk_i);
        wr_i <= 1'b1;
        rmw_i <= m;
        addr_i <= a;
        wdata_i <= d;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
        rmw_i <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge ref_clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1 rd_v = rdata_o;
    endtask
    task automatic final_report();
        $display("Mismatches %0d, compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Hang guard well above the planned run length
    always @(posedge ref_clk_i)
    begin
        cyc++;
        if (cyc > 3000)
        begin
            err_count++;
            final_report();
        end
    end
    initial
    begin
        repeat (16) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        #1;
        chk(pin_oe_n_o, 8'hFF);
        chk(pin_o, 8'h00);
        rd(`AKP_ADDR_INEN);
        chk(rd_v, 8'hFF);
        rd(`AKP_ADDR_DIR);
        chk(rd_v, 8'h00);
        foreach (rows[i])
        begin
            // inputs first, then direction, then enable
            wr(`AKP_ADDR_INEN, 8'hFF, 1'b0);
            wr(`AKP_ADDR_DIR, rows[i].dir, 1'b0);
            wr(`AKP_ADDR_INEN, rows[i].inen, 1'b0);
            wr(`AKP_ADDR_DATA, rows[i].lat, 1'b0);
            ext <= rows[i].ext;
            repeat (3) @(posedge ref_clk_i);
            rd(`AKP_ADDR_DATA);
            chk(rd_v, rows[i].exp);
            chk(pin_oe_n_o, ~rows[i].dir);
            chk(pin_o, rows[i].lat);
            chk(ana_o, ~rows[i].dir & ~rows[i].inen);
        end
        // wakeup pins: direction cleared before stop control
        wr(`AKP_ADDR_DIR, 8'h00, 1'b0);
        wr(`AKP_ADDR_INEN, 8'hFF, 1'b0);
        wr(`AKP_ADDR_STOP, 8'hFF, 1'b0);
        ext <= 8'h5A;
        repeat (3) @(posedge ref_clk_i);
        chk(wake_o, 8'h50);
        rd(`AKP_ADDR_STOP);
        chk(rd_v, 8'hF0);
        // Mixed port: bit manipulation copies pin levels of inputs
        // no conversion runs here, so output writes are free
        wr(`AKP_ADDR_DIR, 8'h0F, 1'b0);
        ext <= 8'hA5;
        repeat (3) @(posedge ref_clk_i);
        wr(`AKP_ADDR_DATA, 8'h3C, 1'b1);
        #1 chk(pin_o, 8'hAC);
        // Unmapped place reads zero and ignores writes
        wr(4'hF, 8'hFF, 1'b0);
        rd(4'hF);
        chk(rd_v, 8'h00);
        rd(`AKP_ADDR_DIR);
        chk(rd_v, 8'h0F);
        // Second reset in mid-run, raised on a clock edge
        @(posedge ref_clk_i);
        rst_i <= 1'b1;
        @(posedge ref_clk_i);
        rst_i <= 1'b0;
        #1 chk(pin_oe_n_o, 8'hFF);
        chk(pin_o, 8'h00);
        rd(`AKP_ADDR_INEN);
        chk(rd_v, 8'hFF);
        rd(`AKP_ADDR_STOP);
        chk(rd_v, 8'h00);
        final_report();
    end
endmodule
